// ===== src/dtf_terminal_logic.sv
`timescale 1ns/1ps
module dtf_terminal_logic #(
    parameter int P_TICK_CYC = dtf_pkg::TICK_CYC
) (
    input  wire logic                       i_core_clk,
    input  wire logic                       i_rstn,
    input  wire logic                       i_clk_en,
    input  wire dtf_pkg::dtf_bus_req_type   i_bus,
    output logic [dtf_pkg::DW-1:0]          o_rdata,
    input  wire logic [dtf_pkg::NTERM-1:0]  i_term_pin,
    input  wire dtf_pkg::dtf_core_sts_type  i_core,
    output dtf_pkg::dtf_drive_cmd_type      o_cmd,
    output logic [dtf_pkg::NREL-1:0]        o_relay,
    output logic [3:0]                      o_plc_stage
);
    import dtf_pkg::*;

    // ==================================================
    // state
    logic [NTERM-1:0]   sync1_r, sync2_r;
    logic [FW-1:0]      term_fn_r [NTERM];
    logic [FW-1:0]      term_fn_nxt [NTERM];
    logic [FW-1:0]      rel_src_r [NREL];
    logic [FW-1:0]      rel_src_nxt [NREL];
    logic [DW-1:0]      pri_r, max_r, min_r, start_r;
    logic [DW-1:0]      pri_nxt, max_nxt, min_nxt, start_nxt;
    logic [1:0]         pid_mode_r, pid_mode_nxt;
    logic [DW-1:0]      tset_r [2];
    logic [DW-1:0]      tset_nxt [2];
    logic [DW-1:0]      cset_r, cmid_r, cset_nxt, cmid_nxt;
    logic [DW-1:0]      freq_r, freq_nxt;
    logic [15:0]        tick_cnt_r, tick_cnt_nxt;
    logic [DW-1:0]      tmr_r [2];
    logic [DW-1:0]      tmr_nxt [2];
    logic [DW-1:0]      cnt_r, cnt_nxt;
    logic [2:0]         gap_r, gap_nxt;
    logic               cnt_prev_r, frst_prev_r;
    logic [3:0]         stage_r, stage_nxt;
    dtf_wind_state_type wind_r, wind_nxt;
    dtf_drive_cmd_type  cmd_r, cmd_nxt;
    logic [NREL-1:0]    relay_r, relay_nxt;
    logic [DW-1:0]      rdata_r, rdata_nxt;
    logic [63:0]        act, sv;
    logic               tick;
    logic [1:0]         tmr_hit;

    // ==================================================
    // pin synchronisers
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else if (i_clk_en) begin
            sync1_r <= i_term_pin;
            sync2_r <= sync1_r;
        end
    end

    // ==================================================
    // function decode
    always_comb begin
        act = '0;
        for (int k = 0; k < NTERM; k++) begin
            if (term_fn_r[k] != '0 && term_fn_r[k] <= FN_MAX) begin
                act[term_fn_r[k]] = act[term_fn_r[k]] | sync2_r[k];
            end
        end
    end

    function automatic logic [3:0] spd_code(input logic [3:0] s);
        case (s)
            4'h1: spd_code = 4'h1;
            4'h2: spd_code = 4'h2;
            4'h4: spd_code = 4'h3;
            4'h8: spd_code = 4'h4;
            4'h3: spd_code = 4'h5;
            4'h5: spd_code = 4'h6;
            4'h9: spd_code = 4'h7;
            4'h6: spd_code = 4'h8;
            4'ha: spd_code = 4'h9;
            4'hc: spd_code = 4'ha;
            4'h7: spd_code = 4'hb;
            4'hb: spd_code = 4'hc;
            4'hd: spd_code = 4'hd;
            4'he: spd_code = 4'he;
            4'hf: spd_code = 4'hf;
            default: spd_code = 4'h0;
        endcase
    endfunction

    assign tick = (tick_cnt_r == 16'(P_TICK_CYC - 1));

    // ==================================================
    // next-state logic
    always_comb begin
        term_fn_nxt  = term_fn_r;
        rel_src_nxt  = rel_src_r;
        pri_nxt      = pri_r;
        max_nxt      = max_r;
        min_nxt      = min_r;
        start_nxt    = start_r;
        pid_mode_nxt = pid_mode_r;
        tset_nxt     = tset_r;
        cset_nxt     = cset_r;
        cmid_nxt     = cmid_r;
        freq_nxt     = freq_r;
        tmr_nxt      = tmr_r;
        cnt_nxt      = cnt_r;
        gap_nxt      = gap_r;
        stage_nxt    = stage_r;
        wind_nxt     = wind_r;
        cmd_nxt      = cmd_r;
        tick_cnt_nxt = tick ? 16'h0000 : tick_cnt_r + 16'h0001;
        if (i_bus.wr) begin
            for (int k = 0; k < NTERM; k++) begin
                if (i_bus.addr == REG_TERM_FN0 + AW'(k)) begin
                    term_fn_nxt[k] = i_bus.wdata[FW-1:0];
                end
            end
            for (int k = 0; k < NREL; k++) begin
                if (i_bus.addr == REG_REL_SRC0 + AW'(k)) begin
                    rel_src_nxt[k] = i_bus.wdata[FW-1:0];
                end
            end
            for (int k = 0; k < 2; k++) begin
                if (i_bus.addr == REG_TMR_SET0 + AW'(k)) begin
                    tset_nxt[k] = i_bus.wdata;
                end
            end
            case (i_bus.addr)
                REG_PRI_FREQ:   pri_nxt = i_bus.wdata;
                REG_MAX_FREQ:   max_nxt = i_bus.wdata;
                REG_MIN_FREQ:   min_nxt = i_bus.wdata;
                REG_START_FREQ: start_nxt = i_bus.wdata;
                REG_PID_MODE:   pid_mode_nxt = i_bus.wdata[1:0];
                REG_CNT_SET:    cset_nxt = i_bus.wdata;
                REG_CNT_MID:    cmid_nxt = i_bus.wdata;
                default: ;
            endcase
        end
        if (i_bus.wr && i_bus.addr == REG_PRI_FREQ) begin
            freq_nxt = i_bus.wdata;
        end else if (tick && act[FN_UP] && !act[FN_DOWN] && freq_r < max_r) begin
            freq_nxt = freq_r + 16'h0001;
        end else if (tick && act[FN_DOWN] && !act[FN_UP] && freq_r > min_r) begin
            freq_nxt = freq_r - 16'h0001;
        end
        for (int k = 0; k < 2; k++) begin
            if (!act[FN_TMR1 + FW'(k)]) begin
                tmr_nxt[k] = '0;
            end else if (tick && tmr_r[k] < tset_r[k]) begin
                tmr_nxt[k] = tmr_r[k] + 16'h0001;
            end
        end
        // edges up to the 4th tick after a counted edge rejected
        if (tick && gap_r != 3'h0) begin
            gap_nxt = gap_r - 3'h1;
        end
        if (act[FN_CRST]) begin
            cnt_nxt = '0;
        end else if (act[FN_CNT] && !cnt_prev_r && gap_r == 3'h0) begin
            gap_nxt = CNT_GAP_TICKS;
            if (cnt_r != 16'hffff) begin
                cnt_nxt = cnt_r + 16'h0001;
            end
        end
        if (act[FN_PLCCLR]) begin
            stage_nxt = 4'h0;
        end else if (act[FN_PLC] && i_core.plc_stage_done) begin
            stage_nxt = stage_r + 4'h1;
        end
        case (wind_r)
            WIND_IDLE: if (act[FN_WIND] && i_core.running) wind_nxt = WIND_RUN;
            WIND_RUN: begin
                if (i_core.wind_done) begin
                    wind_nxt = WIND_DONE;
                end else if (!act[FN_WIND] || !i_core.running) begin
                    wind_nxt = WIND_IDLE;
                end
            end
            WIND_DONE: if (!i_core.running) wind_nxt = WIND_IDLE;
            default: wind_nxt = WIND_IDLE;
        endcase
        cmd_nxt.run = (act[FN_FWD] | act[FN_REV] | act[FN_RUN]) &
                      ~act[FN_STOP] & ~act[FN_COAST];
        cmd_nxt.reverse = (act[FN_REV] & ~act[FN_FWD]) ^ act[FN_DIR_SW];
        cmd_nxt.coast = act[FN_COAST];
        cmd_nxt.speed_sel = spd_code(act[FN_SPD1 +: 4]);
        cmd_nxt.ramp_sel = {act[FN_RAMP2], act[FN_RAMP1]};
        cmd_nxt.fault_reset = act[FN_FRST] & ~frst_prev_r;
        cmd_nxt.pid_en = act[FN_PID] | (pid_mode_r != PID_MODE_GATED && pid_mode_r != 2'h0);
        cmd_nxt.plc_run = act[FN_PLC];
        cmd_nxt.plc_clear = act[FN_PLCCLR];
        cmd_nxt.wind_en = act[FN_WIND];
        cmd_nxt.wind_hold = (wind_nxt == WIND_DONE);
        cmd_nxt.freq = freq_nxt;
    end

    // ==================================================
    // relay sources
    always_comb begin
        for (int k = 0; k < 2; k++) begin
            tmr_hit[k] = act[FN_TMR1 + FW'(k)] && tmr_r[k] >= tset_r[k];
        end
        sv = {31'h0, i_core.other};
        sv[0] = 1'b0;
        sv[SRC_RUN] = i_core.running;
        sv[SRC_FREACH] = i_core.freq_reached;
        sv[SRC_FAULT] = i_core.fault;
        sv[SRC_ZERO] = i_core.out_freq < start_r;
        sv[SRC_TMR1] = tmr_hit[0];
        sv[SRC_TMR1 + 6'h01] = tmr_hit[1];
        sv[SRC_WIND] = (wind_r == WIND_DONE);
        sv[SRC_CNT] = cnt_r >= cset_r;
        sv[SRC_CMID] = cnt_r >= cmid_r;
        // code 0 and above 32 stay off
        for (int k = 0; k < NREL; k++) begin
            relay_nxt[k] = (rel_src_r[k] <= FN_MAX) ? sv[rel_src_r[k]] : 1'b0;
        end
    end

    // ==================================================
    // read mux
    always_comb begin
        rdata_nxt = '0;
        for (int k = 0; k < NTERM; k++) begin
            if (i_bus.addr == REG_TERM_FN0 + AW'(k)) rdata_nxt = DW'(term_fn_r[k]);
        end
        for (int k = 0; k < NREL; k++) begin
            if (i_bus.addr == REG_REL_SRC0 + AW'(k)) rdata_nxt = DW'(rel_src_r[k]);
        end
        for (int k = 0; k < 2; k++) begin
            if (i_bus.addr == REG_TMR_SET0 + AW'(k)) rdata_nxt = tset_r[k];
        end
        case (i_bus.addr)
            REG_PRI_FREQ:   rdata_nxt = pri_r;
            REG_MAX_FREQ:   rdata_nxt = max_r;
            REG_MIN_FREQ:   rdata_nxt = min_r;
            REG_START_FREQ: rdata_nxt = start_r;
            REG_PID_MODE:   rdata_nxt = DW'(pid_mode_r);
            REG_CNT_SET:    rdata_nxt = cset_r;
            REG_CNT_MID:    rdata_nxt = cmid_r;
            REG_STATUS:     rdata_nxt = {5'h00, relay_r, sv[SRC_CMID], sv[SRC_CNT],
                                         tmr_hit, sv[SRC_WIND], i_core.fault,
                                         cmd_r.reverse, cmd_r.run};
            REG_COUNT:      rdata_nxt = cnt_r;
            REG_WORK_FREQ:  rdata_nxt = freq_r;
            default: ;
        endcase
        if (!i_bus.rd) rdata_nxt = '0;
    end

    // ==================================================
    // registers
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            term_fn_r   <= RST_TERM_FN;
            rel_src_r   <= RST_REL_SRC;
            pri_r       <= RST_PRI_FREQ;
            max_r       <= RST_MAX_FREQ;
            min_r       <= RST_MIN_FREQ;
            start_r     <= RST_START_FREQ;
            pid_mode_r  <= 2'h0;
            tset_r      <= '{RST_TMR_SET, RST_TMR_SET};
            cset_r      <= RST_CNT_SET;
            cmid_r      <= RST_CNT_MID;
            freq_r      <= RST_PRI_FREQ;
            tick_cnt_r  <= '0;
            tmr_r       <= '{16'h0000, 16'h0000};
            cnt_r       <= '0;
            gap_r       <= '0;
            cnt_prev_r  <= 1'b0;
            frst_prev_r <= 1'b0;
            stage_r     <= '0;
            wind_r      <= WIND_IDLE;
            cmd_r       <= '{default: '0, freq: RST_PRI_FREQ};
            relay_r     <= '0;
            rdata_r     <= '0;
        end else if (i_clk_en) begin
            term_fn_r   <= term_fn_nxt;
            rel_src_r   <= rel_src_nxt;
            pri_r       <= pri_nxt;
            max_r       <= max_nxt;
            min_r       <= min_nxt;
            start_r     <= start_nxt;
            pid_mode_r  <= pid_mode_nxt;
            tset_r      <= tset_nxt;
            cset_r      <= cset_nxt;
            cmid_r      <= cmid_nxt;
            freq_r      <= freq_nxt;
            tick_cnt_r  <= tick_cnt_nxt;
            tmr_r       <= tmr_nxt;
            cnt_r       <= cnt_nxt;
            gap_r       <= gap_nxt;
            cnt_prev_r  <= act[FN_CNT];
            frst_prev_r <= act[FN_FRST];
            stage_r     <= stage_nxt;
            wind_r      <= wind_nxt;
            cmd_r       <= cmd_nxt;
            relay_r     <= relay_nxt;
            rdata_r     <= rdata_nxt;
        end
    end

    assign o_cmd       = cmd_r;
    assign o_relay     = relay_r;
    assign o_rdata     = rdata_r;
    assign o_plc_stage = stage_r;

    // ==================================================
    // assertions
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rstn);

    sequence s_wind_done;
        wind_r == WIND_DONE;
    endsequence
    sequence s_drive_stops;
        i_clk_en && !i_core.running;
    endsequence
    sequence s_fwd_and_switch;
        i_clk_en && act[FN_FWD] && act[FN_DIR_SW] && !act[FN_STOP] && !act[FN_COAST];
    endsequence

    AST_FWD_SWITCH_REVERSE: assert property (
        s_fwd_and_switch |=> cmd_r.run && cmd_r.reverse)
        else $error("forward with switch did not run reverse");
    AST_STOP_INPUT: assert property (
        i_clk_en && act[FN_STOP] |=> !cmd_r.run)
        else $error("stop input did not stop the drive");
    AST_COAST_INPUT: assert property (
        i_clk_en && act[FN_COAST] |=> cmd_r.coast && !cmd_r.run)
        else $error("coast input did not cut output");
    AST_PRIMARY_SPEED: assert property (
        i_clk_en && act[FN_SPD1 +: 4] == 4'h0 |=> cmd_r.speed_sel == 4'h0)
        else $error("primary frequency not selected");
    AST_RAMP_SELECT: assert property (
        i_clk_en |=> cmd_r.ramp_sel == $past({act[FN_RAMP2], act[FN_RAMP1]}))
        else $error("ramp set index wrong");
    AST_UP_STEP: assert property (
        i_clk_en && tick && act[FN_UP] && !act[FN_DOWN] && freq_r < max_r && !i_bus.wr
        |=> freq_r == $past(freq_r) + 16'h0001)
        else $error("up input did not raise frequency");
    AST_FAULT_RESET_PULSE: assert property (
        i_clk_en && cmd_r.fault_reset |=> !cmd_r.fault_reset)
        else $error("fault reset longer than one cycle");
    AST_WIND_CLEAR: assert property (
        s_wind_done ##0 s_drive_stops |=> wind_r == WIND_IDLE && !cmd_r.wind_hold)
        else $error("winding complete not cleared on stop");
    AST_RELAY_OFF: assert property (
        i_clk_en && rel_src_r[0] == 6'h00 |=> !o_relay[0])
        else $error("relay with source 0 asserted");
    AST_PLC_CLEAR: assert property (
        i_clk_en && act[FN_PLCCLR] |=> stage_r == 4'h0)
        else $error("memory clear did not restart sequence");
    AST_CNT_CLEAR: assert property (
        i_clk_en && act[FN_CRST] |=> cnt_r == 16'h0000)
        else $error("counter reset did not clear count");
endmodule

// ===== src/dtf_pkg.sv
package dtf_pkg;
    // ==================================================
    // sizes and function codes
    localparam int DW = 16;
    localparam int AW = 5;
    localparam int FW = 6;
    localparam int NTERM = 8;
    localparam int NREL = 3;
    localparam logic [FW-1:0] FN_DIR_SW = 6'h04;
    localparam logic [FW-1:0] FN_RUN = 6'h05;
    localparam logic [FW-1:0] FN_FWD = 6'h06;
    localparam logic [FW-1:0] FN_REV = 6'h07;
    localparam logic [FW-1:0] FN_STOP = 6'h08;
    localparam logic [FW-1:0] FN_SPD1 = 6'h09;
    localparam logic [FW-1:0] FN_RAMP1 = 6'h0d;
    localparam logic [FW-1:0] FN_RAMP2 = 6'h0e;
    localparam logic [FW-1:0] FN_UP = 6'h0f;
    localparam logic [FW-1:0] FN_DOWN = 6'h10;
    localparam logic [FW-1:0] FN_COAST = 6'h11;
    localparam logic [FW-1:0] FN_FRST = 6'h12;
    localparam logic [FW-1:0] FN_PID = 6'h13;
    localparam logic [FW-1:0] FN_PLC = 6'h14;
    localparam logic [FW-1:0] FN_TMR1 = 6'h15;
    localparam logic [FW-1:0] FN_CNT = 6'h17;
    localparam logic [FW-1:0] FN_CRST = 6'h18;
    localparam logic [FW-1:0] FN_PLCCLR = 6'h19;
    localparam logic [FW-1:0] FN_WIND = 6'h1a;
    localparam logic [FW-1:0] FN_MAX = 6'h20;
    localparam logic [FW-1:0] SRC_RUN = 6'h01;
    localparam logic [FW-1:0] SRC_FREACH = 6'h02;
    localparam logic [FW-1:0] SRC_FAULT = 6'h03;
    localparam logic [FW-1:0] SRC_ZERO = 6'h04;
    localparam logic [FW-1:0] SRC_TMR1 = 6'h0a;
    localparam logic [FW-1:0] SRC_WIND = 6'h1a;
    localparam logic [FW-1:0] SRC_CNT = 6'h1b;
    localparam logic [FW-1:0] SRC_CMID = 6'h1c;
    localparam logic [1:0] PID_MODE_GATED = 2'h2;
    // ==================================================
    // register map (word index)
    localparam logic [AW-1:0] REG_TERM_FN0 = 5'h00;
    localparam logic [AW-1:0] REG_REL_SRC0 = 5'h08;
    localparam logic [AW-1:0] REG_PRI_FREQ = 5'h0b;
    localparam logic [AW-1:0] REG_MAX_FREQ = 5'h0c;
    localparam logic [AW-1:0] REG_MIN_FREQ = 5'h0d;
    localparam logic [AW-1:0] REG_START_FREQ = 5'h0e;
    localparam logic [AW-1:0] REG_PID_MODE = 5'h0f;
    localparam logic [AW-1:0] REG_TMR_SET0 = 5'h10;
    localparam logic [AW-1:0] REG_CNT_SET = 5'h12;
    localparam logic [AW-1:0] REG_CNT_MID = 5'h13;
    localparam logic [AW-1:0] REG_STATUS = 5'h14;
    localparam logic [AW-1:0] REG_COUNT = 5'h15;
    localparam logic [AW-1:0] REG_WORK_FREQ = 5'h16;
    localparam logic [FW-1:0] RST_TERM_FN [NTERM] =
        '{6'h06, 6'h07, 6'h01, 6'h12, 6'h0f, 6'h10, 6'h08, 6'h09};
    localparam logic [FW-1:0] RST_REL_SRC [NREL] = '{6'h01, 6'h02, 6'h03};
    localparam logic [DW-1:0] RST_PRI_FREQ = 16'h1388;
    localparam logic [DW-1:0] RST_MAX_FREQ = 16'h1388;
    localparam logic [DW-1:0] RST_MIN_FREQ = 16'h0000;
    localparam logic [DW-1:0] RST_START_FREQ = 16'h0032;
    localparam logic [DW-1:0] RST_TMR_SET = 16'h03e8;
    localparam logic [DW-1:0] RST_CNT_SET = 16'h0064;
    localparam logic [DW-1:0] RST_CNT_MID = 16'h0032;
    // ==================================================
    // timing
    localparam int CLK_NS = 40;
    localparam int TICK_NS = 1000000;
    localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_MAX_HZ = 250;
    localparam int MS_PER_S = 1000;
    localparam logic [2:0] CNT_GAP_TICKS = 3'((MS_PER_S + CNT_MAX_HZ - 1) / CNT_MAX_HZ);
    // ==================================================
    // types
    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic          wr;
        logic          rd;
    } dtf_bus_req_type;
    typedef struct packed {
        logic          running;
        logic          freq_reached;
        logic          fault;
        logic          plc_stage_done;
        logic          wind_done;
        logic [DW-1:0] out_freq;
        logic [32:0]   other;
    } dtf_core_sts_type;
    typedef struct packed {
        logic          run;
        logic          reverse;
        logic          coast;
        logic [3:0]    speed_sel;
        logic [1:0]    ramp_sel;
        logic          fault_reset;
        logic          pid_en;
        logic          plc_run;
        logic          plc_clear;
        logic          wind_en;
        logic          wind_hold;
        logic [DW-1:0] freq;
    } dtf_drive_cmd_type;
    typedef enum logic [1:0] {
        WIND_IDLE = 2'b00,
        WIND_RUN  = 2'b01,
        WIND_DONE = 2'b11
    } dtf_wind_state_type;
endpackage

// ===== tb/dtf_core_model.sv
`timescale 1ns/1ps
module dtf_core_model (
    input  wire logic                      i_core_clk,
    input  wire logic                      i_rstn,
    input  wire dtf_pkg::dtf_drive_cmd_type i_cmd,
    input  wire logic                      i_fault,
    output dtf_pkg::dtf_core_sts_type      o_core
);
    import dtf_pkg::*;
    logic wind_prev_r;
    logic plc_prev_r;
    // ==================================================
    // drive core: runs on command, coast drops output at once
    // one stage and one winding pass complete per enable closure
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_core <= '0;
            wind_prev_r <= 1'b0;
            plc_prev_r <= 1'b0;
        end else begin
            o_core.freq_reached <= i_cmd.run;
            o_core.wind_done <= i_cmd.wind_en & ~wind_prev_r;
            o_core.plc_stage_done <= i_cmd.plc_run & ~plc_prev_r;
            wind_prev_r <= i_cmd.wind_en;
            plc_prev_r <= i_cmd.plc_run;
            o_core.running <= i_cmd.run & ~i_cmd.coast;
            o_core.fault <= i_fault;
            o_core.out_freq <= i_cmd.run ? i_cmd.freq : 16'h0000;
        end
    end
endmodule

// ===== tb/drive_terminal_function_logic_tb.sv
`timescale 1ns/1ps
module drive_terminal_function_logic_tb;
    import dtf_pkg::*;
    logic              clk;
    logic              rstn;
    logic              flt;
    logic [7:0]        pin;
    dtf_bus_req_type   bus;
    logic [DW-1:0]     rdata;
    dtf_drive_cmd_type cmd;
    dtf_core_sts_type  core;
    logic [2:0]        rel;
    logic              cke;
    logic [3:0]        stg;
    int                n_frst;
    int                n_fail;
    int                checks_done;
    // select pattern to preset speed index
    localparam logic [3:0] SPD [16] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h3, 4'h6, 4'h8, 4'hb,
        4'h4, 4'h7, 4'h9, 4'hc, 4'ha, 4'hd, 4'he, 4'hf};
    // ==================================================
    // design and core model
    dtf_terminal_logic #(.P_TICK_CYC(4)) u_dtf_terminal_logic (.i_core_clk(clk),
        .i_rstn(rstn), .i_clk_en(cke), .i_bus(bus), .o_rdata(rdata), .i_term_pin(pin),
        .i_core(core), .o_cmd(cmd), .o_relay(rel), .o_plc_stage(stg));
    dtf_core_model u_dtf_core_model (.i_core_clk(clk), .i_rstn(rstn), .i_cmd(cmd),
        .i_fault(flt), .o_core(core));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // fault reset pulses seen on the command
    always @(posedge clk) begin
        if (cmd.fault_reset) n_frst++;
    end
    // ==================================================
    // helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        @(posedge clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 chk(rdata, e, "read");
    endtask
    // settle allows sync flops plus output register
    task automatic setpin(input logic [7:0] p);
        @(posedge clk);
        pin <= p;
        repeat (5) @(posedge clk);
        #1;
    endtask
    // ==================================================
    // scenarios
    task automatic t_regs();
        rd(REG_REL_SRC0, 16'h0001);
        rd(REG_REL_SRC0 + 5'h01, 16'h0002);
        rd(REG_REL_SRC0 + 5'h02, 16'h0003);
        wr(5'h1f, 16'h00aa);
        rd(5'h1f, 16'h0000);
        $display("test regs done");
    endtask
    task automatic t_dir();
        setpin(8'h02);
        chk(16'({cmd.run, cmd.reverse}), 16'h0003, "rev");
        wr(REG_TERM_FN0 + 5'h01, {10'h000, FN_DIR_SW});
        setpin(8'h01);
        chk(16'({cmd.run, cmd.reverse}), 16'h0002, "fwd");
        setpin(8'h03);
        chk(16'({cmd.run, cmd.reverse}), 16'h0003, "switch");
        setpin(8'h00);
        chk(16'({cmd.run, cmd.reverse}), 16'h0000, "stop");
        $display("test dir done");
    endtask
    task automatic t_spd();
        for (int i = 0; i < 4; i++) begin
            wr(REG_TERM_FN0 + 5'(i + 2), {10'h000, FN_SPD1 + 6'(i)});
        end
        wr(REG_TERM_FN0 + 5'h06, {10'h000, FN_RAMP1});
        wr(REG_TERM_FN0 + 5'h07, {10'h000, FN_RAMP2});
        for (int p = 0; p < 16; p++) begin
            setpin({2'(p), 4'(p), 2'b00});
            chk(16'(cmd.speed_sel), 16'(SPD[p]), "speed");
            chk(16'(cmd.ramp_sel), 16'(p % 4), "ramp");
        end
        $display("test speed done");
    endtask
    task automatic t_stop();
        wr(REG_TERM_FN0 + 5'h06, {10'h000, FN_COAST});
        setpin(8'h41);
        chk(16'({cmd.run, cmd.coast}), 16'h0001, "coast");
        wr(REG_TERM_FN0 + 5'h06, {10'h000, FN_STOP});
        setpin(8'h41);
        chk(16'(cmd.run), 16'h0000, "stop");
        wr(REG_TERM_FN0, 16'h0000);
        setpin(8'h01);
        chk(16'(cmd.run), 16'h0000, "no fn");
        $display("test stop done");
    endtask
    task automatic t_relay();
        wr(REG_TERM_FN0, {10'h000, FN_FWD});
        wr(REG_REL_SRC0 + 5'h01, {10'h000, SRC_ZERO});
        setpin(8'h01);
        chk(16'(rel), 16'h0001, "running");
        wr(REG_REL_SRC0, 16'h0000);
        flt <= 1'b1;
        setpin(8'h00);
        chk(16'(rel), 16'h0006, "fault zero");
        $display("test relay done");
    endtask
    task automatic t_misc();
        flt <= 1'b0;
        cke <= 1'b0;
        setpin(8'h01);
        chk(16'(cmd.run), 16'h0000, "frozen");
        cke <= 1'b1;
        setpin(8'h00);
        wr(REG_TERM_FN0 + 5'h01, {10'h000, FN_UP});
        wr(REG_TERM_FN0 + 5'h02, {10'h000, FN_DOWN});
        wr(REG_TERM_FN0 + 5'h03, {10'h000, FN_FRST});
        wr(REG_TERM_FN0 + 5'h04, {10'h000, FN_CNT});
        wr(REG_TERM_FN0 + 5'h05, {10'h000, FN_CRST});
        wr(REG_TERM_FN0 + 5'h06, {10'h000, FN_WIND});
        wr(REG_TERM_FN0 + 5'h07, {10'h000, FN_PLC});
        wr(REG_MIN_FREQ, 16'h1386);
        setpin(8'h04);
        repeat (40) @(posedge clk);
        rd(REG_WORK_FREQ, 16'h1386);
        rd(REG_PRI_FREQ, 16'h1388);
        setpin(8'h02);
        repeat (40) @(posedge clk);
        rd(REG_WORK_FREQ, 16'h1388);
        setpin(8'h08);
        repeat (10) @(posedge clk);
        chk(16'(n_frst), 16'h0001, "frst");
        wr(REG_TERM_FN0 + 5'h03, {10'h000, FN_PID});
        wr(REG_PID_MODE, 16'h0002);
        setpin(8'h00);
        chk(16'(cmd.pid_en), 16'h0000, "pid off");
        setpin(8'h08);
        chk(16'(cmd.pid_en), 16'h0001, "pid on");
        // pulses spaced well beyond the accepted minimum gap
        repeat (3) begin
            setpin(8'h10);
            setpin(8'h00);
            repeat (12) @(posedge clk);
        end
        rd(REG_COUNT, 16'h0003);
        setpin(8'h20);
        rd(REG_COUNT, 16'h0000);
        wr(REG_TERM_FN0 + 5'h05, {10'h000, FN_TMR1});
        wr(REG_TMR_SET0, 16'h0002);
        wr(REG_REL_SRC0, {10'h000, SRC_TMR1});
        setpin(8'h20);
        repeat (12) @(posedge clk);
        chk(16'(rel[0]), 16'h0001, "timer");
        setpin(8'h00);
        chk(16'(rel[0]), 16'h0000, "timer off");
        wr(REG_TERM_FN0 + 5'h05, {10'h000, FN_PLCCLR});
        setpin(8'h80);
        chk(16'(stg), 16'h0001, "stage");
        setpin(8'h00);
        setpin(8'h80);
        chk(16'(stg), 16'h0002, "stage kept");
        setpin(8'h20);
        chk(16'(stg), 16'h0000, "stage clr");
        wr(REG_REL_SRC0, {10'h000, SRC_FREACH});
        setpin(8'h01);
        setpin(8'h41);
        chk(16'(cmd.wind_hold), 16'h0001, "wind");
        chk(16'(rel), 16'h0001, "reached");
        setpin(8'h40);
        chk(16'(cmd.wind_hold), 16'h0000, "wind stop");
        $display("test misc done");
    endtask
    // ==================================================
    // sequence, watchdog and verdict
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        rstn = 1'b0;
        pin = 8'h00;
        bus = '0;
        flt = 1'b0;
        cke = 1'b1;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        t_regs();
        t_dir();
        t_spd();
        t_stop();
        t_relay();
        t_misc();
        close_out();
    end
    // whole run is under 1500 cycles
    initial begin
        #200000;
        n_fail++;
        close_out();
    end
endmodule
